// *** flash_host_regs.svh ***
`ifndef FLASH_HOST_REGS_SVH
`define FLASH_HOST_REGS_SVH
// Summary of operation
// - Protection word program: write C0 at target, then the data word there.
// - After program, read status repeatedly until ready flag is 1.
// - After the final program, write FF to return to array read.
// - Word program: 40 or 10 anywhere, then data at target.
// - Sector erase: 20 anywhere, then D0 inside the sector.
// - Write 70, then the next read at any address returns status.
`define CMD_READ_ARRAY   8'hff
`define CMD_PROGRAM      8'h40
`define CMD_ERASE_SETUP  8'h20
`define CMD_CONFIRM      8'hd0
`define CMD_SUSPEND      8'hb0
`define CMD_READ_ID      8'h90
`define CMD_QUERY        8'h98
`define CMD_LOCK_SETUP   8'h60
`define CMD_SOFT_LOCK    8'h01
`define CMD_HARD_LOCK    8'h2f
`define CMD_READ_STATUS  8'h70
`define CMD_CLEAR_STATUS 8'h50
`define CMD_PROT_SETUP   8'hc0
`define PROT_LOCK_ADDR   21'h000080
`define PROT_LOCK_DATA   16'hfffd
`define PROT_FIRST       8'h81
`define PROT_LAST        8'h88
`define USER_LOCK_BIT    1
`define ST_SECTOR_LOCKED 1
`define ST_PROG_SUSP     2
`define ST_SUPPLY_ERR    3
`define ST_PROG_ERR      4
`define ST_ERASE_SUSP    6
`define ST_READY         7
`define SMALL_SHIFT      12
`define BIG_SHIFT        15
`define BOOT_SECTORS     7'h08
`define CLK_PERIOD_NS    5
`define T_ACC_NS         70
`define T_WP_NS          35
`define ACC_CYC          ((`T_ACC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WP_CYC           ((`T_WP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// *** flash_host_pkg.sv ***
package flash_host_pkg;
   typedef enum logic [3:0] {
      OP_READ_ARRAY = 4'h0, OP_PROGRAM = 4'h1, OP_ERASE = 4'h2, OP_SUSPEND = 4'h3,
      OP_RESUME = 4'h4, OP_READ_ID = 4'h5, OP_QUERY = 4'h6, OP_SOFT_LOCK = 4'h7,
      OP_HARD_LOCK = 4'h8, OP_UNLOCK = 4'h9, OP_READ_STATUS = 4'ha, OP_CLEAR_STATUS = 4'hb,
      OP_PROT_PROGRAM = 4'hc, OP_PROT_LOCK = 4'hd, OP_LOCK_STATE = 4'he
   } op_t;
   typedef enum logic [2:0] {
      ERR_NONE = 3'h0, ERR_SUPPLY = 3'h1, ERR_PROGRAM = 3'h2, ERR_LOCKED = 3'h3, ERR_OTHER = 3'h4
   } err_t;
   typedef enum logic [6:0] {
      S_IDLE = 7'h01, S_CYC1 = 7'h02, S_CYC2 = 7'h04, S_READ = 7'h08,
      S_POLL = 7'h10, S_EXIT = 7'h20, S_DONE = 7'h40
   } state_t;
   typedef enum logic [3:0] {
      C_IDLE = 4'h1, C_SETUP = 4'h2, C_STROBE = 4'h4, C_RECOVER = 4'h8
   } cyc_state_t;
   typedef struct packed {
      op_t         op;
      logic [20:0] addr;
      logic [15:0] data;
   } req_t;
   typedef struct packed {
      logic [15:0] rdata;
      logic [7:0]  status;
      err_t        err;
      logic        refused;
      logic        user_prot_locked;
      logic [6:0]  sector;
   } resp_t;
   typedef struct packed {
      logic [7:0]  c1;
      logic        two;
      logic [20:0] a2;
      logic [15:0] d2;
      logic        rd;
      logic [20:0] ra;
      logic        poll;
      logic        fin;
   } plan_t;
endpackage

// *** flash_bus_cycle.sv ***
`timescale 1ns/100ps
module flash_bus_cycle #(
   parameter int ACC_CYC = 14,
   parameter int WP_CYC  = 7
) (
   // System
   input  wire logic        clk_sys,
   input  wire logic        rst,
   // Cycle request
   input  wire logic        start,
   input  wire logic        wr,
   input  wire logic [20:0] addr_in,
   input  wire logic [15:0] wdata,
   output logic             done,
   output logic [15:0]      rdata,
   // Flash pins
   output logic             ce_n,
   output logic             oe_n,
   output logic             we_n,
   output logic [20:0]      addr,
   output logic [15:0]      dq_o,
   output logic             dq_oe_n,
   input  wire logic [15:0] dq_i
);
   flash_host_pkg::cyc_state_t state_reg;
   logic [7:0] cnt_reg;
   logic       wr_reg;
   logic [7:0] last;

   assign last = wr_reg ? 8'(WP_CYC - 1) : 8'(ACC_CYC - 1);

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_reg <= flash_host_pkg::C_IDLE;
         cnt_reg <= 8'h00;
         wr_reg <= 1'b0;
      end else begin
         case (state_reg)
            flash_host_pkg::C_IDLE: begin
               if (start) begin
                  state_reg <= flash_host_pkg::C_SETUP;
                  wr_reg <= wr;
               end
            end
            flash_host_pkg::C_SETUP: begin
               state_reg <= flash_host_pkg::C_STROBE;
               cnt_reg <= 8'h00;
            end
            flash_host_pkg::C_STROBE: begin
               cnt_reg <= cnt_reg + 8'h01;
               if (cnt_reg == last) state_reg <= flash_host_pkg::C_RECOVER;
            end
            default: state_reg <= flash_host_pkg::C_IDLE;
         endcase
      end
   end

   // Chip enable drops for every cycle, so each status read sees fresh contents
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ce_n <= 1'b1;
         oe_n <= 1'b1;
         we_n <= 1'b1;
         addr <= 21'h000000;
         dq_o <= 16'h0000;
         dq_oe_n <= 1'b1;
         rdata <= 16'h0000;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         case (state_reg)
            flash_host_pkg::C_IDLE: begin
               if (start) begin
                  addr <= addr_in;
                  dq_o <= wdata;
                  ce_n <= 1'b0;
                  dq_oe_n <= ~wr;
               end
            end
            flash_host_pkg::C_SETUP: begin
               we_n <= ~wr_reg;
               oe_n <= wr_reg;
            end
            flash_host_pkg::C_STROBE: begin
               if (cnt_reg == last) begin
                  we_n <= 1'b1;
                  oe_n <= 1'b1;
                  if (!wr_reg) rdata <= dq_i;
               end
            end
            default: begin
               // Data held one cycle past the write strobe rising edge
               ce_n <= 1'b1;
               dq_oe_n <= 1'b1;
               done <= 1'b1;
            end
         endcase
      end
   end
endmodule

// *** flash_host_ctrl.sv ***
`timescale 1ns/100ps
`include "flash_host_regs.svh"
module flash_host_ctrl #(
   parameter int ACC_CYC = `ACC_CYC,
   parameter int WP_CYC  = `WP_CYC
) (
   // System
   input  wire logic                   clk_sys,
   input  wire logic                   rst,
   // User request
   input  wire logic                   req_valid,
   input  wire flash_host_pkg::req_t   req,
   output logic                        req_ready,
   // User response
   output logic                        resp_valid,
   output flash_host_pkg::resp_t       resp,
   // Flash pins
   output logic                        flash_ce_n,
   output logic                        flash_oe_n,
   output logic                        flash_we_n,
   output logic [20:0]                 flash_addr,
   output logic [15:0]                 flash_dq_o,
   output logic                        flash_dq_oe_n,
   input  wire logic [15:0]            flash_dq_i
);
   flash_host_pkg::state_t state_reg;
   flash_host_pkg::state_t state_next;
   flash_host_pkg::req_t   cur_reg;
   flash_host_pkg::plan_t  plan_reg;
   logic                   pend_reg;
   logic                   bus_start_reg;
   logic                   bus_wr_next;
   logic [20:0]            bus_addr_next;
   logic [15:0]            bus_wdata_next;
   logic                   bus_done;
   logic [15:0]            bus_rdata;
   logic                   supply_hold_reg;
   logic                   accept;
   logic                   poll_ready;

   function automatic flash_host_pkg::plan_t plan_of(input flash_host_pkg::req_t r);
      flash_host_pkg::plan_t p;
      p = '0;
      p.a2 = r.addr;
      p.ra = r.addr;
      case (r.op)
         flash_host_pkg::OP_READ_ARRAY: begin
            p.c1 = `CMD_READ_ARRAY;
            p.rd = 1'b1;
         end
         flash_host_pkg::OP_PROGRAM: begin
            p.c1 = `CMD_PROGRAM;
            p.two = 1'b1;
            p.d2 = r.data;
            p.poll = 1'b1;
            p.fin = 1'b1;
         end
         flash_host_pkg::OP_ERASE: begin
            p.c1 = `CMD_ERASE_SETUP;
            p.two = 1'b1;
            p.d2 = {8'h00, `CMD_CONFIRM};
            p.poll = 1'b1;
            p.fin = 1'b1;
         end
         flash_host_pkg::OP_SUSPEND: begin
            p.c1 = `CMD_SUSPEND;
            p.poll = 1'b1;
         end
         flash_host_pkg::OP_RESUME: p.c1 = `CMD_CONFIRM;
         flash_host_pkg::OP_READ_ID: begin
            p.c1 = `CMD_READ_ID;
            p.rd = 1'b1;
         end
         flash_host_pkg::OP_QUERY: begin
            p.c1 = `CMD_QUERY;
            p.rd = 1'b1;
         end
         flash_host_pkg::OP_SOFT_LOCK, flash_host_pkg::OP_HARD_LOCK, flash_host_pkg::OP_UNLOCK: begin
            p.c1 = `CMD_LOCK_SETUP;
            p.two = 1'b1;
            if (r.op == flash_host_pkg::OP_SOFT_LOCK) p.d2 = {8'h00, `CMD_SOFT_LOCK};
            else if (r.op == flash_host_pkg::OP_HARD_LOCK) p.d2 = {8'h00, `CMD_HARD_LOCK};
            else p.d2 = {8'h00, `CMD_CONFIRM};
         end
         flash_host_pkg::OP_READ_STATUS: begin
            p.c1 = `CMD_READ_STATUS;
            p.rd = 1'b1;
         end
         flash_host_pkg::OP_CLEAR_STATUS: p.c1 = `CMD_CLEAR_STATUS;
         flash_host_pkg::OP_PROT_PROGRAM: begin
            p.c1 = `CMD_PROT_SETUP;
            p.two = 1'b1;
            p.d2 = r.data;
            p.poll = 1'b1;
            p.fin = 1'b1;
         end
         flash_host_pkg::OP_PROT_LOCK: begin
            p.c1 = `CMD_PROT_SETUP;
            p.two = 1'b1;
            p.a2 = `PROT_LOCK_ADDR;
            p.d2 = `PROT_LOCK_DATA;
            p.poll = 1'b1;
            p.fin = 1'b1;
         end
         default: begin
            p.c1 = `CMD_READ_ID;
            p.rd = 1'b1;
            p.ra = `PROT_LOCK_ADDR;
         end
      endcase
      return p;
   endfunction

   // Upper address lines must be zero for protection words
   function automatic logic prot_addr_ok(input logic [20:0] a);
      return (a[20:8] == 13'h0000) && (a[7:0] >= `PROT_FIRST) && (a[7:0] <= `PROT_LAST);
   endfunction

   function automatic flash_host_pkg::err_t err_of(input logic [7:0] s);
      case ({s[`ST_SECTOR_LOCKED], s[`ST_SUPPLY_ERR], s[`ST_PROG_ERR]})
         3'h0: return flash_host_pkg::ERR_NONE;
         3'h3: return flash_host_pkg::ERR_SUPPLY;
         3'h1: return flash_host_pkg::ERR_PROGRAM;
         3'h5: return flash_host_pkg::ERR_LOCKED;
         default: return flash_host_pkg::ERR_OTHER;
      endcase
   endfunction

   // Bottom-boot map only
   function automatic logic [6:0] sector_of(input logic [20:0] a);
      if (a[20:`BIG_SHIFT] == 6'h00) return {4'h0, a[`BIG_SHIFT-1:`SMALL_SHIFT]};
      return 7'(a[20:`BIG_SHIFT]) + `BOOT_SECTORS - 7'h01;
   endfunction

   // Refusing locally saves a doomed cycle pair; the device would flag it anyway
   function automatic logic refuse_of(input flash_host_pkg::req_t r, input logic hold);
      logic prog;
      prog = (r.op == flash_host_pkg::OP_PROGRAM) || (r.op == flash_host_pkg::OP_PROT_PROGRAM)
             || (r.op == flash_host_pkg::OP_PROT_LOCK);
      return (prog && hold)
             || (r.op == flash_host_pkg::OP_PROT_PROGRAM && !prot_addr_ok(r.addr));
   endfunction

   assign accept = req_valid && req_ready && state_reg == flash_host_pkg::S_IDLE;
   assign poll_ready = bus_rdata[`ST_READY];

   always_comb begin
      state_next = state_reg;
      bus_wr_next = 1'b1;
      bus_addr_next = cur_reg.addr;
      bus_wdata_next = {8'h00, plan_reg.c1};
      case (state_reg)
         flash_host_pkg::S_CYC1: begin
            if (plan_reg.two) state_next = flash_host_pkg::S_CYC2;
            else if (plan_reg.rd) state_next = flash_host_pkg::S_READ;
            else if (plan_reg.poll) state_next = flash_host_pkg::S_POLL;
            else state_next = flash_host_pkg::S_DONE;
         end
         flash_host_pkg::S_CYC2: begin
            bus_addr_next = plan_reg.a2;
            bus_wdata_next = plan_reg.d2;
            if (plan_reg.rd) state_next = flash_host_pkg::S_READ;
            else if (plan_reg.poll) state_next = flash_host_pkg::S_POLL;
            else state_next = flash_host_pkg::S_DONE;
         end
         flash_host_pkg::S_READ: begin
            bus_wr_next = 1'b0;
            bus_addr_next = plan_reg.ra;
            state_next = flash_host_pkg::S_DONE;
         end
         flash_host_pkg::S_POLL: begin
            bus_wr_next = 1'b0;
            if (poll_ready) state_next = plan_reg.fin ? flash_host_pkg::S_EXIT : flash_host_pkg::S_DONE;
         end
         flash_host_pkg::S_EXIT: begin
            bus_wdata_next = {8'h00, `CMD_READ_ARRAY};
            state_next = flash_host_pkg::S_DONE;
         end
         default: ;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_reg <= flash_host_pkg::S_IDLE;
         cur_reg <= '0;
         plan_reg <= '0;
      end else begin
         case (state_reg)
            flash_host_pkg::S_IDLE: begin
               if (accept) begin
                  cur_reg <= req;
                  plan_reg <= plan_of(req);
                  state_reg <= refuse_of(req, supply_hold_reg) ? flash_host_pkg::S_DONE
                                                               : flash_host_pkg::S_CYC1;
               end
            end
            flash_host_pkg::S_DONE: state_reg <= flash_host_pkg::S_IDLE;
            default: if (pend_reg && bus_done) state_reg <= state_next;
         endcase
      end
   end

   // One bus cycle per visit; a status poll re-enters and toggles chip enable again
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pend_reg <= 1'b0;
         bus_start_reg <= 1'b0;
      end else begin
         bus_start_reg <= 1'b0;
         if (state_reg != flash_host_pkg::S_IDLE && state_reg != flash_host_pkg::S_DONE) begin
            if (!pend_reg) begin
               pend_reg <= 1'b1;
               bus_start_reg <= 1'b1;
            end else if (bus_done) begin
               pend_reg <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) req_ready <= 1'b1;
      else if (accept) req_ready <= 1'b0;
      else if (state_reg == flash_host_pkg::S_DONE) req_ready <= 1'b1;
   end

   // A supply error seen while polling wins over a clear in the same cycle
   always_ff @(posedge clk_sys) begin
      if (rst) supply_hold_reg <= 1'b0;
      else if (state_reg == flash_host_pkg::S_POLL && pend_reg && bus_done && poll_ready
               && bus_rdata[`ST_SUPPLY_ERR]) supply_hold_reg <= 1'b1;
      else if (state_reg == flash_host_pkg::S_CYC1 && pend_reg && bus_done
               && cur_reg.op == flash_host_pkg::OP_CLEAR_STATUS) supply_hold_reg <= 1'b0;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         resp <= '0;
         resp_valid <= 1'b0;
      end else begin
         resp_valid <= state_reg == flash_host_pkg::S_DONE;
         if (accept) begin
            resp <= '0;
            resp.sector <= sector_of(req.addr);
            resp.refused <= refuse_of(req, supply_hold_reg);
         end
         if (state_reg == flash_host_pkg::S_POLL && pend_reg && bus_done && poll_ready) begin
            resp.status <= bus_rdata[7:0];
            resp.err <= err_of(bus_rdata[7:0]);
         end
         if (state_reg == flash_host_pkg::S_READ && pend_reg && bus_done) begin
            resp.rdata <= bus_rdata;
            resp.user_prot_locked <= ~bus_rdata[`USER_LOCK_BIT];
            if (cur_reg.op == flash_host_pkg::OP_READ_STATUS) begin
               resp.status <= bus_rdata[7:0];
               resp.err <= err_of(bus_rdata[7:0]);
            end
         end
      end
   end

   flash_bus_cycle #(
      .ACC_CYC (ACC_CYC),
      .WP_CYC  (WP_CYC)
   ) u_cycle (
      .clk_sys (clk_sys),
      .rst     (rst),
      .start   (bus_start_reg),
      .wr      (bus_wr_next),
      .addr_in (bus_addr_next),
      .wdata   (bus_wdata_next),
      .done    (bus_done),
      .rdata   (bus_rdata),
      .ce_n    (flash_ce_n),
      .oe_n    (flash_oe_n),
      .we_n    (flash_we_n),
      .addr    (flash_addr),
      .dq_o    (flash_dq_o),
      .dq_oe_n (flash_dq_oe_n),
      .dq_i    (flash_dq_i)
   );
endmodule

// *** flash_host_ctrl_chk.sv ***
`timescale 1ns/100ps
module flash_host_ctrl_chk #(
   parameter int ACC_CYC = 14,
   parameter int WP_CYC  = 7
) (
   // System
   input wire logic                  clk_sys,
   input wire logic                  rst,
   // User side
   input wire logic                  req_valid,
   input wire flash_host_pkg::req_t  req,
   input wire logic                  req_ready,
   input wire logic                  resp_valid,
   input wire flash_host_pkg::resp_t resp,
   // Flash pins
   input wire logic                  flash_ce_n,
   input wire logic                  flash_oe_n,
   input wire logic                  flash_we_n,
   input wire logic [15:0]           flash_dq_o,
   input wire logic                  flash_dq_oe_n,
   input wire logic [15:0]           flash_dq_i
);
   logic [3:0] op_reg;
   logic [7:0] wr_reg;
   logic [7:0] rd_reg;

   always_ff @(posedge clk_sys) if (req_valid && req_ready) op_reg <= req.op;
   always_ff @(posedge clk_sys) if (!flash_we_n) wr_reg <= flash_dq_o[7:0];
   always_ff @(posedge clk_sys) if (!flash_oe_n) rd_reg <= flash_dq_i[7:0];

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence take_s(logic [3:0] o);
      req_valid && req_ready && req.op == o;
   endsequence
   // A refused request answers without any bus write, so the answer also ends the wait
   sequence setup_s(logic [7:0] c);
      ##[1:8] ((!flash_we_n && flash_dq_o[7:0] == c) || resp_valid);
   endsequence

   strobe_excl_a: assert property (flash_we_n || flash_oe_n)
      else $error("read and write strobes overlap");
   drive_write_a: assert property (!flash_dq_oe_n |-> flash_oe_n && !flash_ce_n)
      else $error("data driven outside a write cycle");
   take_busy_a: assert property (req_valid && req_ready |=> !req_ready && !resp_valid)
      else $error("request taken while busy or answered too early");
   resp_pulse_a: assert property (resp_valid |-> req_ready ##1 !resp_valid)
      else $error("response pulse malformed");
   prog_setup_a: assert property (take_s(4'h1) |-> setup_s(8'h40))
      else $error("program setup code missing");
   erase_setup_a: assert property (take_s(4'h2) |-> setup_s(8'h20))
      else $error("erase setup code missing");
   prot_setup_a: assert property (take_s(4'hc) |-> setup_s(8'hc0))
      else $error("protection setup code missing");
   status_cmd_a: assert property (take_s(4'ha) |-> setup_s(8'h70))
      else $error("status command missing");
   poll_ready_a: assert property (resp_valid && op_reg == 4'h1 && !resp.refused |-> rd_reg[7] && resp.status[7])
      else $error("program answered before ready");
   read_exit_a: assert property (resp_valid && op_reg inside {4'h1, 4'h2, 4'hc, 4'hd} && !resp.refused
                                 |-> wr_reg == 8'hff)
      else $error("no array read command after program or erase");
endmodule

bind flash_host_ctrl flash_host_ctrl_chk #(.ACC_CYC(ACC_CYC), .WP_CYC(WP_CYC)) u_chk (
   .clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
   .resp_valid(resp_valid), .resp(resp), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
   .flash_we_n(flash_we_n), .flash_dq_o(flash_dq_o), .flash_dq_oe_n(flash_dq_oe_n), .flash_dq_i(flash_dq_i));

// *** flash_dev_model.sv ***
`timescale 1ns/100ps
module flash_dev_model (
   // Flash pins
   input  wire logic        ce_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   input  wire logic [20:0] addr,
   input  wire logic [15:0] dq_o,
   input  wire logic        dq_oe_n,
   output logic [15:0]      dq_i,
   // Test control
   input  wire logic [1:0]  fault,
   input  wire logic [3:0]  busy_len,
   output logic [7:0]       last_byte
);
   logic [15:0] mem [logic [20:0]];
   bit          lock_tab [int];
   logic [7:0]  status_reg = 8'h00;
   logic [7:0]  pend_reg = 8'h00;
   logic [1:0]  mode_reg = 2'h0;
   logic        erasing_reg = 1'b0;
   logic        prot_locked_reg = 1'b0;
   logic [15:0] drv;
   logic [15:0] held = 16'h0000;
   int          busy = 0;

   function automatic int sec_of(input logic [20:0] a);
      return (a < 21'h008000) ? int'(a[14:12]) : int'(a[20:15]) + 7;
   endfunction

   always @(posedge we_n) begin : wr_blk
      logic [7:0] c;
      logic [7:0] p;
      c = dq_o[7:0];
      p = pend_reg;
      if (!ce_n && !dq_oe_n) begin
         last_byte = c;
         pend_reg = 8'h00;
         case (p)
            8'h40, 8'h10: begin
               erasing_reg = 1'b0;
               mode_reg = 2'h1;
               if (fault == 2'h1) status_reg[4:3] = 2'h3;
               else if (fault == 2'h2) status_reg[4] = 1'b1;
               else if (lock_tab.exists(sec_of(addr))) status_reg[4:1] = 4'h9;
               else if (!status_reg[3]) begin
                  mem[addr] = dq_o;
                  busy = busy_len;
               end
            end
            8'h20: if (c == 8'hd0) begin
               erasing_reg = 1'b1;
               busy = busy_len;
               mode_reg = 2'h1;
            end
            8'h60: if (c == 8'h01 || c == 8'h2f) lock_tab[sec_of(addr)] = 1'b1;
               else if (c == 8'hd0) lock_tab.delete(sec_of(addr));
            8'hc0: begin
               mode_reg = 2'h1;
               if (addr[7:0] == 8'h80 && dq_o == 16'hfffd) prot_locked_reg = 1'b1;
               else if (addr[20:8] != 13'h0000 || addr[7:0] < 8'h81 || addr[7:0] > 8'h88)
                  status_reg[4] = 1'b1;
               else busy = busy_len;
            end
            default: case (c)
               8'hff: mode_reg = 2'h0;
               8'h70: mode_reg = 2'h1;
               8'h90, 8'h98: mode_reg = 2'h2;
               8'h50: status_reg = status_reg & 8'hc5;
               8'hb0: begin
                  if (busy > 0) status_reg[erasing_reg ? 6 : 2] = 1'b1;
                  busy = 0;
                  mode_reg = 2'h1;
               end
               8'hd0: status_reg = status_reg & 8'hbb;
               8'h40, 8'h10, 8'h20, 8'h60, 8'hc0: pend_reg = c;
               default: ;
            endcase
         endcase
      end
   end

   // Each status read counts down the busy time
   always @(posedge oe_n) if (!ce_n && mode_reg == 2'h1 && busy > 0) busy = busy - 1;
   // Released lines show the inverse of the last value rather than holding it
   always @(posedge oe_n or posedge ce_n) held <= ~drv;
   always @* begin
      if (mode_reg == 2'h1) drv = {8'h00, busy == 0, status_reg[6:0]};
      else if (mode_reg == 2'h2) drv = (addr[7:0] == 8'h80) ? {14'h0000, ~prot_locked_reg, 1'b0} : 16'h0000;
      else drv = mem.exists(addr) ? mem[addr] : 16'hffff;
   end
   assign dq_i = (!ce_n && !oe_n) ? drv : held;
endmodule

// *** flash_host_ctrl_tb_top.sv ***
`timescale 1ns/100ps
module flash_host_ctrl_tb_top;
   logic                  clk_sys;
   logic                  rst;
   logic                  req_valid;
   flash_host_pkg::req_t  req;
   logic                  req_ready;
   logic                  resp_valid;
   flash_host_pkg::resp_t resp;
   flash_host_pkg::resp_t rs;
   logic                  ce_n, oe_n, we_n, dq_oe_n;
   logic [20:0]           fa;
   logic [15:0]           dq_o, dq_i;
   logic [1:0]            fault;
   logic [3:0]            busy_len;
   logic [7:0]            last_byte;
   int                    error_cnt;
   int                    n_compared;
   logic [20:0]           sec_a [4] = '{21'h000000, 21'h007fff, 21'h008000, 21'h1fffff};
   logic [6:0]            sec_e [4] = '{7'h00, 7'h07, 7'h08, 7'h46};
   logic [3:0]            misc_op [3] = '{4'h5, 4'h6, 4'h4};
   logic [7:0]            misc_cmd [3] = '{8'h90, 8'h98, 8'hd0};

   flash_host_ctrl #(.ACC_CYC(2), .WP_CYC(2)) dut (
      .clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
      .resp_valid(resp_valid), .resp(resp), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
      .flash_addr(fa), .flash_dq_o(dq_o), .flash_dq_oe_n(dq_oe_n), .flash_dq_i(dq_i));
   flash_dev_model dev (
      .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(fa), .dq_o(dq_o), .dq_oe_n(dq_oe_n), .dq_i(dq_i),
      .fault(fault), .busy_len(busy_len), .last_byte(last_byte));

   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   task automatic close_out();
      if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // One request, held for the single edge that takes it, then the answer is kept in rs
   task automatic run(input logic [3:0] op, input logic [20:0] a, input logic [15:0] d);
      int n;
      @(posedge clk_sys);
      #1;
      req_valid = 1'b1;
      req = '{op: flash_host_pkg::op_t'(op), addr: a, data: d};
      @(posedge clk_sys);
      #1;
      req_valid = 1'b0;
      n = 0;
      while (resp_valid !== 1'b1 && n < 400) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      cmp(resp_valid, 1'b1, "no answer");
      rs = resp;
   endtask

   initial begin
      #100000;
      error_cnt++;
      $display("BAD %0t watchdog expired", $time);
      close_out();
   end

   initial begin
      error_cnt = 0;
      n_compared = 0;
      rst = 1'b1;
      req_valid = 1'b0;
      req = '0;
      fault = 2'h0;
      busy_len = 4'h3;
      repeat (8) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      cmp({req_ready, resp_valid, ce_n, we_n, oe_n, dq_oe_n}, 6'h2f, "idle pins");
      run(4'h1, 21'h012345, 16'hbeef);
      cmp(rs.status, 8'h80, "program status");
      cmp(last_byte, 8'hff, "final write");
      run(4'h0, 21'h012345, 16'h0000);
      cmp(rs.rdata, 16'hbeef, "array data");
      run(4'ha, 21'h1fffff, 16'h0000);
      cmp(rs.rdata, 16'h0080, "status read");
      for (int i = 0; i < 4; i++) begin
         run(4'h2, sec_a[i], 16'h0000);
         cmp(rs.sector, sec_e[i], "sector");
      end
      fault = 2'h2;
      run(4'h1, 21'h000100, 16'h1111);
      cmp(rs.err, 3'h2, "program fail code");
      fault = 2'h0;
      run(4'ha, 21'h000000, 16'h0000);
      cmp(rs.rdata, 16'h0090, "flag kept");
      run(4'hb, 21'h000000, 16'h0000);
      fault = 2'h1;
      run(4'h1, 21'h000100, 16'h1111);
      cmp(rs.err, 3'h1, "supply code");
      fault = 2'h0;
      run(4'h1, 21'h000100, 16'h1111);
      cmp(rs.refused, 1'b1, "program held off");
      run(4'hc, 21'h000082, 16'h1111);
      cmp(rs.refused, 1'b1, "protection held off");
      run(4'hb, 21'h000000, 16'h0000);
      run(4'h1, 21'h000100, 16'h2222);
      cmp({rs.refused, rs.err}, 4'h0, "program after clear");
      for (int i = 0; i < 2; i++) begin
         run(i == 0 ? 4'h7 : 4'h8, 21'h008100, 16'h0000);
         cmp(last_byte, i == 0 ? 8'h01 : 8'h2f, "lock code");
         run(4'h1, 21'h00f000, 16'h3333);
         cmp(rs.err, 3'h3, "locked code");
         run(4'hb, 21'h000000, 16'h0000);
         run(4'h9, 21'h00c000, 16'h0000);
         cmp(last_byte, 8'hd0, "unlock code");
      end
      run(4'h1, 21'h00f000, 16'h3333);
      cmp(rs.err, 3'h0, "unlocked program");
      run(4'hc, 21'h100081, 16'h5555);
      cmp(rs.refused, 1'b1, "high address");
      run(4'hc, 21'h000080, 16'h5555);
      cmp(rs.refused, 1'b1, "below range");
      run(4'hc, 21'h000088, 16'h5555);
      cmp({rs.refused, rs.err}, 4'h0, "last word");
      run(4'he, 21'h000000, 16'h0000);
      cmp(rs.user_prot_locked, 1'b0, "open state");
      run(4'hd, 21'h000000, 16'h0000);
      cmp({rs.refused, rs.err, last_byte}, 12'h0ff, "lock word");
      run(4'he, 21'h000000, 16'h0000);
      cmp(rs.user_prot_locked, 1'b1, "locked state");
      run(4'h3, 21'h000000, 16'h0000);
      cmp({rs.status[7:6], rs.status[2]}, 3'h4, "suspend flags");
      for (int i = 0; i < 3; i++) begin
         run(misc_op[i], 21'h000000, 16'h0000);
         cmp(last_byte, misc_cmd[i], "single command");
      end
      close_out();
   end
endmodule
